// ===== bench/dac_frontend_monitor.sv
// Checker of the serial front end outputs
`timescale 1ns/1ps
module dac_frontend_monitor (
  // Watched ports
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        frameSyncB,
  input wire logic        serialOut,
  input wire logic [15:0] updateWord,
  input wire logic        updateStrobe,
  input wire logic        frameAbort
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_ZERO: assert property (
    !$past(rst_b) |-> updateWord == 16'h0000) else $error("word not zero");
  AST_ANSWER: assert property (
    $rose(frameSyncB) |-> ##[2:8] (updateStrobe || frameAbort))
    else $error("frame end not answered");
  AST_ONE: assert property (
    updateStrobe |-> frameSyncB ##1 !updateStrobe) else $error("bad strobe");
  AST_EXCL: assert property (
    frameAbort |-> !updateStrobe ##1 !frameAbort) else $error("bad abort");
  AST_HOLD: assert property (
    !updateStrobe |-> $stable(updateWord)) else $error("word moved");
  AST_IDLE: assert property (
    frameSyncB [*8] |-> !serialOut) else $error("data out not idle");
endmodule

bind octal_dac_serial_frontend dac_frontend_monitor dac_frontend_monitor_i (
  .sys_clk, .rst_b, .frameSyncB, .serialOut, .updateWord, .updateStrobe,
  .frameAbort);

// ===== bench/octal_dac_serial_frontend_tb_top.sv
// Self-checking bench of the serial front end
`timescale 1ns/1ps
module octal_dac_serial_frontend_tb_top;
  import dac_frontend_pkg::*;
  logic        sys_clk, rst_b, frameSyncB, serialClk, serialIn, serialOut;
  logic        chanWriteEn, chanPowerDown, updateStrobe, frameAbort;
  logic [7:0]  chanSelect;
  logic [11:0] channelOutput [8];
  logic [15:0] updateWord, last;
  term_t       chanTerm;
  term_t       chanMode [8];
  int          errors, n_checks, seed, cyc = 0;
  octal_dac_serial_frontend octal_dac_serial_frontend_i (.sys_clk, .rst_b,
    .clkEn(1'b1), .frameSyncB, .serialClk, .serialIn, .serialOut,
    .chanSelect, .chanWriteEn, .chanPowerDown, .chanTerm, .channelOutput,
    .chanMode, .updateWord, .updateStrobe, .frameAbort);
  serial_host_model serial_host_model_i (.frameSyncB, .serialClk, .serialIn);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic expOut(logic [31:0] v, int n);
    return n > 16 ? v[16] : 1'b0;
  endfunction
  task automatic frame(input logic [31:0] v, input int n);
    logic s, a;
    s = 1'b0;
    a = 1'b0;
    fork
      serial_host_model_i.send(v, n);
      #(160 * n + 40) check("sdo", {15'h0, serialOut}, {15'h0, expOut(v, n)});
    join
    repeat (10) begin
      @(negedge sys_clk);
      s |= updateStrobe === 1'b1;
      a |= frameAbort === 1'b1;
    end
    if (n >= 16) last = v[15:0];
    check("strobe", {15'h0, s}, {15'h0, n >= 16});
    check("abort", {15'h0, a}, {15'h0, n < 16});
    check("word", updateWord, last);
    check("out0", {4'h0, channelOutput[0]}, {4'h0, last[11:0]});
    check("out2", {4'h0, channelOutput[2]}, 16'h0000);
  endtask
  initial begin
    seed = 98;
    errors = 0;
    n_checks = 0;
    last = 16'h0000;
    rst_b = 1'b0;
    {chanWriteEn, chanPowerDown, chanSelect} = '0;
    chanTerm = TERM_ACTIVE;
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("out1", {4'h0, channelOutput[1]}, 16'h0000);
    for (int t = 1; t < 4; t++) begin
      chanSelect    = 8'h01 << t;
      chanPowerDown = 1'b1;
      chanTerm      = term_t'(t);
      chanWriteEn = 1'b1;
      @(negedge sys_clk);
      chanWriteEn = 1'b0;
      @(negedge sys_clk);
      check("mode", {14'h0, chanMode[t]}, t[15:0]);
    end
    chanSelect    = 8'h08;
    chanPowerDown = 1'b0;
    chanWriteEn   = 1'b1;
    @(negedge sys_clk);
    chanWriteEn = 1'b0;
    @(negedge sys_clk);
    check("mode3", {14'h0, chanMode[3]}, 16'h0000);
    chanSelect = 8'hFF;
    frame(32'h0000A5C3, 16);
    frame($random(seed), 15);
    frame($random(seed), 14);
    repeat (3) frame($random(seed), 16);
    frame($random(seed), 20);
    end_of_test();
  end
endmodule

// ===== bench/serial_host_model.sv
// Serial master that writes frames into the front end
`timescale 1ns/1ps
module serial_host_model (
  // Link pins
  output logic frameSyncB,
  output logic serialClk,
  output logic serialIn
);
  initial begin
    frameSyncB = 1'b1;
    serialClk = 1'b1;
    serialIn = 1'b0;
  end
  // Frame of n bits, MSB first, clock idles high
  task automatic send(input logic [31:0] bits, input int n);
    frameSyncB = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = bits[i];
      #80 serialClk = 1'b0;
      #80 serialClk = 1'b1;
    end
    #80 frameSyncB = 1'b1;
    serialIn = ~serialIn;
  endtask
endmodule

// ===== rtl/octal_dac_serial_frontend.sv
// Serial write front end of an eight-channel voltage-output converter
`timescale 1ns/1ps

// What this block does
// [RULE1] Outputs held at zero until first valid frame
// [RULE2] Per-channel power-down with three termination choices
// [RULE3] Shift data input on falling clock edges
// [RULE4] Host lowers frame sync, then presents data
// [RULE5] Sixteen edges then sync rise updates converter
// [RULE6] Sync rise before fifteenth edge aborts frame
// [RULE7] Data output forwards bits beyond sixteen edges
// [RULE8] Rise after fifteen, before sixteen discards frame
module octal_dac_serial_frontend (
  // Clock, reset, enable
  input  wire logic                                  sys_clk,
  input  wire logic                                  rst_b,
  input  wire logic                                  clkEn,
  // Serial link pins
  input  wire logic                                  frameSyncB,
  input  wire logic                                  serialClk,
  input  wire logic                                  serialIn,
  output logic                                       serialOut,
  // Channel writes
  input  wire logic [dac_frontend_pkg::CHANNELS-1:0] chanSelect,
  input  wire logic                                  chanWriteEn,
  input  wire logic                                  chanPowerDown,
  input  wire dac_frontend_pkg::term_t               chanTerm,
  // Converter side
  output logic [dac_frontend_pkg::CODE_BITS-1:0]     channelOutput [8],
  output dac_frontend_pkg::term_t                    chanMode [8],
  output logic [dac_frontend_pkg::WORD_BITS-1:0]     updateWord,
  output logic                                       updateStrobe,
  output logic                                       frameAbort
);
  import dac_frontend_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0]           syncSync;
    logic [1:0]           clkSync;
    logic [1:0]           dataSync;
    logic                 clkPrev;
    logic                 syncPrev;
    link_state_t          linkState;
    logic [CNT_BITS-1:0]  edgeCount;
    logic [WORD_BITS-1:0] shiftReg;
    logic                 serialOut;
    logic [WORD_BITS-1:0] updateWord;
    logic                 updateStrobe;
    logic                 frameAbort;
    logic                 written;
    logic [CHANNELS-1:0][CODE_BITS-1:0] code;
    logic [CHANNELS-1:0][1:0]           mode;
  } state_t;

  state_t st;
  state_t next_st;

  logic clkFall;
  logic syncFall;
  logic syncRise;

  // ****************************************
  // Edge detection
  // ****************************************
  // Only the second synchroniser stage feeds any decision, so a pin
  // that changes near a clock edge cannot split into two readings.
  // The serial clock needs each phase to last longer than one system clock,
  // otherwise an edge can slip between two samples and be lost.
  assign clkFall  = st.clkPrev & ~st.clkSync[1];
  assign syncFall = st.syncPrev & ~st.syncSync[1];
  assign syncRise = ~st.syncPrev & st.syncSync[1];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;

    // Pin synchronisers and edge history
    next_st.syncSync = {st.syncSync[0], frameSyncB};
    next_st.clkSync  = {st.clkSync[0], serialClk};
    next_st.dataSync = {st.dataSync[0], serialIn};
    next_st.clkPrev  = st.clkSync[1];
    next_st.syncPrev = st.syncSync[1];

    // Pulses last a single cycle
    next_st.updateStrobe = 1'b0;
    next_st.frameAbort   = 1'b0;

    // Frame control
    unique case (st.linkState)
      LINK_IDLE: begin
        if (syncFall) begin  // see [RULE4]
          next_st.linkState = LINK_SHIFT;
          next_st.edgeCount = '0;
        end
      end
      LINK_SHIFT: begin
        if (syncRise) begin
          next_st.linkState = LINK_IDLE;
          if (st.edgeCount >= CNT_FULL) begin  // see [RULE5]
            next_st.updateWord   = st.shiftReg;
            next_st.updateStrobe = 1'b1;
            next_st.written      = 1'b1;  // see [RULE1]
          end else begin
            // Fewer than sixteen edges: the shifted bits are dropped
            next_st.frameAbort = 1'b1;  // see [RULE6] see [RULE8]
          end
        end else if (clkFall) begin
          next_st.shiftReg = {st.shiftReg[WORD_BITS-2:0],
                              st.dataSync[1]};  // see [RULE3]
          // Saturating count keeps long chained frames from wrapping
          if (st.edgeCount != CNT_SAT) begin
            next_st.edgeCount = st.edgeCount + 6'h01;
          end
          // MSB leaves first toward the next device in the chain
          if (st.edgeCount >= CNT_FULL) begin
            next_st.serialOut = st.shiftReg[WORD_BITS-1];  // see [RULE7]
          end
        end
      end
    endcase

    // Daisy chain output rests low between frames
    if (st.linkState == LINK_IDLE) begin
      next_st.serialOut = 1'b0;  // see [RULE7]
    end

    // Channel codes follow the update word only after a valid frame
    if (st.written && st.updateStrobe) begin  // see [RULE1]
      for (int i = 0; i < CHANNELS; i++) begin
        if (chanSelect[i] && (st.mode[i] == 2'h0)) begin
          next_st.code[i] = st.updateWord[CODE_BITS-1:0];
        end
      end
    end

    // Power-down and termination choice per channel
    for (int i = 0; i < CHANNELS; i++) begin
      if (chanWriteEn && chanSelect[i]) begin  // see [RULE2]
        next_st.mode[i] = chanPowerDown ? chanTerm : TERM_ACTIVE;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Edge history is preset to the idle level of each pin, so no false
  // edge follows the release of reset.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st.syncSync     <= 2'h3;
      st.clkSync      <= 2'h3;
      st.dataSync     <= 2'h0;
      st.clkPrev      <= 1'b1;
      st.syncPrev     <= 1'b1;
      st.linkState    <= LINK_IDLE;
      st.edgeCount    <= '0;
      st.shiftReg     <= WORD_RESET;
      st.serialOut    <= 1'b0;
      st.updateWord   <= WORD_RESET;
      st.updateStrobe <= 1'b0;
      st.frameAbort   <= 1'b0;
      st.written      <= 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
        st.code[i] <= CODE_RESET;  // see [RULE1]
        st.mode[i] <= TERM_ACTIVE;
      end
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a plain wire from a state flip-flop
  assign serialOut    = st.serialOut;
  assign updateWord   = st.updateWord;
  assign updateStrobe = st.updateStrobe;
  assign frameAbort   = st.frameAbort;

  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    assign channelOutput[g] = st.code[g];
    assign chanMode[g]      = term_t'(st.mode[g]);
  end

endmodule

// ===== shared/dac_frontend_pkg.sv
// Shared constants and types for the octal converter serial front end
package dac_frontend_pkg;

  // ****************************************
  // Frame geometry
  // ****************************************
  localparam int unsigned WORD_BITS     = 16;
  localparam int unsigned CHANNELS      = 8;
  localparam int unsigned CODE_BITS     = 12;
  localparam int unsigned CNT_BITS      = 6;
  localparam logic [5:0]  CNT_FULL      = 6'h10;
  localparam logic [5:0]  CNT_SAT       = 6'h3F;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [11:0] CODE_RESET    = 12'h000;

  // ****************************************
  // Power-down termination modes
  // ****************************************
  typedef enum logic [1:0] {
    TERM_ACTIVE  = 2'h0,
    TERM_2K5     = 2'h1,
    TERM_100K    = 2'h2,
    TERM_FLOAT   = 2'h3
  } term_t;

  typedef enum {
    LINK_IDLE,
    LINK_SHIFT
  } link_state_t;

endpackage
